// ---- hdl/capture_conditioning.sv ----
// input capture conditioning for channels 0, 2 and 3 of a general timer
`timescale 1ns/1ps
`include "capture_defines.svh"

module capture_conditioning #(
    parameter int NCH = 3
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input capture_pkg::reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    input wire logic chan0_pin,
    input wire logic chan1_pin,
    input wire logic chan2_pin,
    input wire logic chan3_pin,
    input wire logic chan0_active,
    input wire logic chan2_active,
    input wire logic chan3_active,
    input wire logic internal_trigger_select,
    input wire logic filter_base_clock,
    output logic [NCH-1:0] capture_event,
    output logic [NCH-1:0] chan_is_input
);
    import capture_pkg::*;

    // the channel mapping below is written for exactly three channels
    if (NCH != 3) begin : g_bad_nch
        $error("capture_conditioning: NCH must be 3");
    end

    // two filters per channel: own pin and partner pin
    localparam int NFLT = 2 * NCH;

    // field registers, readback, routing and divider state
    chan_fields_t fld_r [NCH], fld_nxt [NCH];
    logic [31:0] rdata_r, rdata_nxt;
    logic [NCH-1:0] active;
    logic [3:0] flt_cfg [NFLT];
    logic [NFLT-1:0] flt_pin, flt_out;
    logic [NCH-1:0] sel_in, prev_r, prev_nxt, cap_r, cap_nxt;
    logic [2:0] edge_cnt_r [NCH], edge_cnt_nxt [NCH];
    logic [2:0] need [NCH];
    logic [NCH-1:0] edge_seen;
    chan_fields_t wr_slice [NCH];
    logic hit_word0, hit_word1;

    // channel index 0 is timer channel 0, 1 is channel 2, 2 is channel 3
    assign active = {chan3_active, chan2_active, chan0_active};

    // write slices: channel 0 in word 0, channels 2 and 3 in word 1
    assign wr_slice[0] = reg_req.wdata[`SLICE_LO_LSB +: `SLICE_W];
    assign wr_slice[1] = reg_req.wdata[`SLICE_LO_LSB +: `SLICE_W];
    assign wr_slice[2] = reg_req.wdata[`SLICE_HI_LSB +: `SLICE_W];

    // word decode shared by writes and reads
    assign hit_word0 = reg_req.addr == `OFF_CTL_WORD_0;
    assign hit_word1 = reg_req.addr == `OFF_CTL_WORD_1;

    // control word writes; a direction field is refused while its channel runs
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            fld_nxt[i] = fld_r[i];
        end
        if (reg_req.wr_en && hit_word0) begin
            fld_nxt[0].input_filter_cfg = wr_slice[0].input_filter_cfg;
            fld_nxt[0].capture_divider = wr_slice[0].capture_divider;
            if (!active[0]) begin
                fld_nxt[0].direction_select = wr_slice[0].direction_select;
            end
        end
        if (reg_req.wr_en && hit_word1) begin
            for (int i = 1; i < NCH; i++) begin
                fld_nxt[i].input_filter_cfg = wr_slice[i].input_filter_cfg;
                fld_nxt[i].capture_divider = wr_slice[i].capture_divider;
                if (!active[i]) begin
                    fld_nxt[i].direction_select = wr_slice[i].direction_select;
                end
            end
        end
    end

    // field registers, all zero out of reset
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < NCH; i++) begin
                fld_r[i] <= chan_fields_t'(`SLICE_RESET);
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                fld_r[i] <= fld_nxt[i];
            end
        end
    end

    // readback; reserved bits and unmapped offsets read as zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_req.rd_en) begin
            rdata_nxt = `CTL_RESET;
            if (hit_word0) begin
                rdata_nxt[`SLICE_LO_LSB +: `SLICE_W] = fld_r[0];
            end else if (hit_word1) begin
                rdata_nxt[`SLICE_LO_LSB +: `SLICE_W] = fld_r[1];
                rdata_nxt[`SLICE_HI_LSB +: `SLICE_W] = fld_r[2];
            end
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdata_r <= `CTL_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // registered read data onto the bus
    assign reg_rdata = rdata_r;

    // filter inputs: own pin with own cfg, partner pin with own cfg
    always_comb begin
        flt_pin = {chan2_pin, chan3_pin, chan3_pin, chan2_pin, chan1_pin, chan0_pin};
        flt_cfg[0] = fld_r[0].input_filter_cfg;
        flt_cfg[1] = fld_r[0].input_filter_cfg;
        flt_cfg[2] = fld_r[1].input_filter_cfg;
        flt_cfg[3] = fld_r[1].input_filter_cfg;
        flt_cfg[4] = fld_r[2].input_filter_cfg;
        flt_cfg[5] = fld_r[2].input_filter_cfg;
    end

    // one synchroniser and filter per routed pin
    for (genvar g = 0; g < NFLT; g++) begin : g_flt
        input_filter #(
            .CNT_W(4)
        ) u_flt (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .pin(flt_pin[g]),
            .filter_base_tick(filter_base_clock),
            .cfg(flt_cfg[g]),
            .filtered(flt_out[g])
        );
    end

    // input routing by direction selector
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            case (fld_r[i].direction_select)
                `DIR_OWN: sel_in[i] = flt_out[2*i];
                `DIR_PAIR: sel_in[i] = flt_out[2*i+1];
                `DIR_TRIG: sel_in[i] = internal_trigger_select;
                default: sel_in[i] = 1'b0;
            endcase
            chan_is_input[i] = fld_r[i].direction_select != `DIR_OUTPUT;
        end
    end

    // rising edge of the routed input; prev resets low like an idle input
    assign prev_nxt = sel_in;
    assign edge_seen = sel_in & ~prev_r;

    // edge count at which a capture falls, per divider code
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            case (fld_r[i].capture_divider)
                `DIV_EVERY_1: need[i] = `DIV_LAST_1;
                `DIV_EVERY_2: need[i] = `DIV_LAST_2;
                `DIV_EVERY_4: need[i] = `DIV_LAST_4;
                default: need[i] = `DIV_LAST_8;
            endcase
        end
    end

    // capture division; count held at zero while stopped or in output mode
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            cap_nxt[i] = 1'b0;
            edge_cnt_nxt[i] = edge_cnt_r[i];
            if (!active[i] || !chan_is_input[i]) begin
                edge_cnt_nxt[i] = '0;
            end else if (edge_seen[i]) begin
                if (edge_cnt_r[i] >= need[i]) begin
                    edge_cnt_nxt[i] = '0;
                    cap_nxt[i] = 1'b1;
                end else begin
                    edge_cnt_nxt[i] = edge_cnt_r[i] + 3'h1;
                end
            end
        end
    end

    // edge detector, divider counts and capture pulse registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prev_r <= '0;
            cap_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                edge_cnt_r[i] <= '0;
            end
        end else begin
            prev_r <= prev_nxt;
            cap_r <= cap_nxt;
            for (int i = 0; i < NCH; i++) begin
                edge_cnt_r[i] <= edge_cnt_nxt[i];
            end
        end
    end

    // one-cycle capture pulse per channel
    assign capture_event = cap_r;
endmodule : capture_conditioning

// ---- include/capture_defines.svh ----
// register offsets, field positions, reset values and filter figures
`ifndef CAPTURE_DEFINES_SVH
`define CAPTURE_DEFINES_SVH

`define ADDR_W 8
`define OFF_CTL_WORD_0 8'h18
`define OFF_CTL_WORD_1 8'h1c
`define CTL_RESET 32'h0000_0000

// field positions inside one 8-bit channel slice
`define FLD_DIR_LSB 0
`define FLD_DIV_LSB 2
`define FLD_FLT_LSB 4
`define SLICE_W 8
`define SLICE_LO_LSB 0
`define SLICE_HI_LSB 8

// direction selector codes
`define DIR_OUTPUT 2'h0
`define DIR_OWN 2'h1
`define DIR_PAIR 2'h2
`define DIR_TRIG 2'h3

// capture divider codes and the edge count at which a capture falls
`define DIV_EVERY_1 2'h0
`define DIV_EVERY_2 2'h1
`define DIV_EVERY_4 2'h2
`define DIV_EVERY_8 2'h3
`define DIV_LAST_1 3'h0
`define DIV_LAST_2 3'h1
`define DIV_LAST_4 3'h3
`define DIV_LAST_8 3'h7

// reset value of one channel slice
`define SLICE_RESET 8'h00

// filter figures: consecutive sample counts and base-tick dividers
`define FLT_OFF 4'h0
`define FLT_N2 4'h2
`define FLT_N4 4'h4
`define FLT_N5 4'h5
`define FLT_N6 4'h6
`define FLT_N8 4'h8
`define FLT_SRC_KERNEL 3'h0
`define FLT_SRC_DIV2 3'h1
`define FLT_SRC_DIV4 3'h2
`define FLT_SRC_DIV8 3'h3
`define FLT_SRC_DIV16 3'h4
`define FLT_SRC_DIV32 3'h5

`endif

// ---- include/capture_pkg.sv ----
// types shared by the capture conditioning block
package capture_pkg;
    typedef enum logic [1:0] {
        dir_output = 2'h0,
        dir_own = 2'h1,
        dir_pair = 2'h2,
        dir_trig = 2'h3
    } dir_sel_t;

    // one channel slice of a control word
    typedef struct packed {
        logic [3:0] input_filter_cfg;
        logic [1:0] capture_divider;
        logic [1:0] direction_select;
    } chan_fields_t;

    // word-wide register access
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
endpackage : capture_pkg

// ---- hdl/input_filter.sv ----
// input synchroniser and digital level filter for one channel input
`timescale 1ns/1ps
`include "capture_defines.svh"

module input_filter #(
    parameter int CNT_W = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic pin,
    input wire logic filter_base_tick,
    input wire logic [3:0] cfg,
    output logic filtered
);
    // the counter must reach the longest consecutive count
    if (CNT_W < 4) begin : g_bad_cnt_w
        $error("input_filter: CNT_W too small for count of 8");
    end

    logic sync1_r, sync2_r;
    logic [4:0] div_r, div_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic out_r, out_nxt;
    logic [3:0] need;
    logic [2:0] src;
    logic sample_en;

    // table of consecutive counts and sampling rates
    always_comb begin
        need = `FLT_N8;
        src = `FLT_SRC_KERNEL;
        case (cfg)
            4'h0: begin need = `FLT_OFF; src = `FLT_SRC_KERNEL; end
            4'h1: begin need = `FLT_N2; src = `FLT_SRC_KERNEL; end
            4'h2: begin need = `FLT_N4; src = `FLT_SRC_KERNEL; end
            4'h3: begin need = `FLT_N8; src = `FLT_SRC_KERNEL; end
            4'h4: begin need = `FLT_N6; src = `FLT_SRC_DIV2; end
            4'h5: begin need = `FLT_N8; src = `FLT_SRC_DIV2; end
            4'h6: begin need = `FLT_N6; src = `FLT_SRC_DIV4; end
            4'h7: begin need = `FLT_N8; src = `FLT_SRC_DIV4; end
            4'h8: begin need = `FLT_N6; src = `FLT_SRC_DIV8; end
            4'h9: begin need = `FLT_N8; src = `FLT_SRC_DIV8; end
            4'ha: begin need = `FLT_N5; src = `FLT_SRC_DIV16; end
            4'hb: begin need = `FLT_N6; src = `FLT_SRC_DIV16; end
            4'hc: begin need = `FLT_N8; src = `FLT_SRC_DIV16; end
            4'hd: begin need = `FLT_N5; src = `FLT_SRC_DIV32; end
            4'he: begin need = `FLT_N6; src = `FLT_SRC_DIV32; end
            default: begin need = `FLT_N8; src = `FLT_SRC_DIV32; end
        endcase
    end

    // sample enable every cycle for the kernel source, else from the base tick divided by a power of two
    always_comb begin
        div_nxt = filter_base_tick ? div_r + 5'h01 : div_r;
        case (src)
            `FLT_SRC_KERNEL: sample_en = 1'b1;
            `FLT_SRC_DIV2: sample_en = filter_base_tick && (div_r[0] == 1'b0);
            `FLT_SRC_DIV4: sample_en = filter_base_tick && (div_r[1:0] == 2'h0);
            `FLT_SRC_DIV8: sample_en = filter_base_tick && (div_r[2:0] == 3'h0);
            `FLT_SRC_DIV16: sample_en = filter_base_tick && (div_r[3:0] == 4'h0);
            default: sample_en = filter_base_tick && (div_r == 5'h00);
        endcase
    end

    // accept a new level after enough consecutive differing samples
    always_comb begin
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        if (need == `FLT_OFF) begin
            cnt_nxt = '0;
            out_nxt = sync2_r;
        end else if (sample_en) begin
            if (sync2_r == out_r) begin
                cnt_nxt = '0;
            end else if (cnt_r + 1'b1 >= CNT_W'(need)) begin
                cnt_nxt = '0;
                out_nxt = sync2_r;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            div_r <= '0;
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign filtered = out_r;
endmodule : input_filter

// ---- dv/capture_conditioning_properties.sv ----
// port checker for the capture conditioning block
`timescale 1ns/1ps
module capture_conditioning_properties #(
    parameter int NCH = 3
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input capture_pkg::reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    input wire logic chan0_active,
    input wire logic chan2_active,
    input wire logic [NCH-1:0] capture_event,
    input wire logic [NCH-1:0] chan_is_input
);
    import capture_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    logic mapped;
    // reads that hit one of the two control words
    assign mapped = reg_req.addr == 8'h18 || reg_req.addr == 8'h1c;
    a_read_unmapped: assert property (disable iff (!resetn)
        reg_req.rd_en && !mapped |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    a_upper_zero: assert property (disable iff (!resetn)
        reg_req.rd_en && reg_req.addr == 8'h1c |=> reg_rdata[31:16] == 16'h0)
        else $error("upper half of word not zero");
    a_read_holds: assert property (disable iff (!resetn)
        !reg_req.rd_en |=> $stable(reg_rdata)) else $error("read data moved without read");
    a_reset_clear: assert property (
        !resetn |=> reg_rdata == 32'h0 && capture_event == '0 && chan_is_input == '0)
        else $error("outputs not cleared by reset");
    a_idle_silent: assert property (disable iff (!resetn)
        !chan0_active [*3] |-> !capture_event[0]) else $error("capture while inactive");
    a_output_silent: assert property (disable iff (!resetn)
        !chan_is_input[0] [*3] |-> !capture_event[0]) else $error("capture in output mode");
    a_dir_locked: assert property (disable iff (!resetn)
        chan0_active && $past(chan0_active) && $past(resetn) |-> $stable(chan_is_input[0]))
        else $error("direction changed while active");
    a_dir_locked_hi: assert property (disable iff (!resetn)
        chan2_active && $past(chan2_active) && $past(resetn) |-> $stable(chan_is_input[1]))
        else $error("channel 2 direction changed while active");
    a_event_single: assert property (disable iff (!resetn)
        capture_event[0] |=> !capture_event[0])
        else $error("capture pulse longer than one cycle");
    c_cap_lo: cover property (capture_event[0]);
    c_cap_hi: cover property (capture_event[2]);
    c_locked_write: cover property (chan0_active && reg_req.wr_en);
endmodule : capture_conditioning_properties

bind capture_conditioning capture_conditioning_properties #(.NCH(NCH))
    i_capture_conditioning_properties (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .chan0_active(chan0_active), .chan2_active(chan2_active),
    .capture_event(capture_event), .chan_is_input(chan_is_input));

// ---- dv/pin_source.sv ----
// edge source for the channel inputs and the internal trigger
`timescale 1ns/1ps
module pin_source (
    input wire logic sys_clk,
    output logic [4:0] lines
);
    initial lines = 5'h0;
    // n rising edges on one line, w cycles high and w low
    task automatic edges(input int src, input int n, input int w);
        repeat (n) begin
            repeat (w) @(posedge sys_clk);
            #1 lines[src] = 1'b1;
            repeat (w) @(posedge sys_clk);
            #1 lines[src] = 1'b0;
        end
    endtask : edges
endmodule : pin_source

// ---- dv/capture_conditioning_tb.sv ----
// self-checking bench for capture conditioning
`timescale 1ns/1ps
module capture_conditioning_tb;
    import capture_pkg::*;
    typedef struct {
        logic [7:0] addr;
        logic [31:0] wd;
        int src, n, w, b, exp;
    } row_t;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    reg_req_t req = '0;
    logic [31:0] reg_rdata;
    logic [4:0] lines;
    logic [2:0] act = 3'h0;
    logic tick = 1'b0;
    logic [1:0] dir;
    logic [2:0] capture_event;
    logic [2:0] chan_is_input;
    int bad_count = 0;
    int tests_run = 0;
    int cnt[3];
    int k = 0;
    // addr, word, source line, edges, width, event bit, captures
    // short pulses against long filters must give no capture
    row_t rows[17] = '{
        '{8'h18, 32'h01, 0, 8, 4, 0, 8}, '{8'h18, 32'h05, 0, 8, 4, 0, 4},
        '{8'h18, 32'h09, 0, 8, 4, 0, 2}, '{8'h18, 32'h0d, 0, 8, 4, 0, 1},
        '{8'h18, 32'h02, 1, 4, 4, 0, 4}, '{8'h18, 32'h03, 4, 4, 4, 0, 4},
        '{8'h18, 32'h11, 0, 4, 8, 0, 4}, '{8'h18, 32'h41, 0, 2, 64, 0, 2},
        '{8'h18, 32'h31, 0, 4, 4, 0, 0}, '{8'h18, 32'h41, 0, 2, 16, 0, 0},
        '{8'h18, 32'h00, 0, 4, 4, 0, 0}, '{8'h1c, 32'h0005, 2, 8, 4, 1, 4},
        '{8'h1c, 32'h0006, 3, 8, 4, 1, 4}, '{8'h1c, 32'h0e00, 2, 8, 4, 2, 1},
        '{8'h1c, 32'h0700, 4, 8, 4, 2, 4}, '{8'h1c, 32'h0031, 2, 4, 4, 1, 0},
        '{8'h1c, 32'h3100, 3, 4, 4, 2, 0}
    };
    always #2.5 sys_clk = ~sys_clk;
    // filter base pulse every fourth cycle
    always @(posedge sys_clk) begin
        #1 tick = (k % 4 == 0);
        k++;
    end
    // capture tally, taken mid-cycle where the pulse has settled
    always @(negedge sys_clk) begin
        for (int i = 0; i < 3; i++) cnt[i] += int'(capture_event[i]);
    end
    capture_conditioning i_capture_conditioning (.sys_clk(sys_clk), .resetn(resetn),
        .reg_req(req), .reg_rdata(reg_rdata), .chan0_pin(lines[0]), .chan1_pin(lines[1]),
        .chan2_pin(lines[2]), .chan3_pin(lines[3]), .chan0_active(act[0]),
        .chan2_active(act[1]), .chan3_active(act[2]), .internal_trigger_select(lines[4]),
        .filter_base_clock(tick), .capture_event(capture_event), .chan_is_input(chan_is_input));
    pin_source i_pin_source (.sys_clk(sys_clk), .lines(lines));
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    // one whole-word bus cycle, read data compared once it stands
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        #1 req = '{w, ~w, a, d};
        @(posedge sys_clk);
        #1 req = '0;
        @(posedge sys_clk);
        #1;
        if (!w) check("rdata", d, reg_rdata);
    endtask : bus
    task automatic settle_check(input int b, input int e);
        repeat (12) @(posedge sys_clk);
        #1;
        check("captures", e, cnt[b]);
    endtask : settle_check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 resetn = 1'b1;
        foreach (rows[i]) begin
            act = 3'h0;
            bus(1, rows[i].addr, rows[i].wd);
            bus(0, rows[i].addr, rows[i].wd);
            dir = rows[i].b == 2 ? rows[i].wd[9:8] : rows[i].wd[1:0];
            check("is_input", 32'(dir != 2'h0), 32'(chan_is_input[rows[i].b]));
            act = 3'h7;
            cnt[rows[i].b] = 0;
            i_pin_source.edges(rows[i].src, rows[i].n, rows[i].w);
            settle_check(rows[i].b, rows[i].exp);
            $display("row %0d done", i);
        end
        // direction held while active, divider still taken
        act = 3'h0;
        bus(1, 8'h18, 32'h05);
        act = 3'h1;
        bus(1, 8'h18, 32'h0c);
        bus(0, 8'h18, 32'h0d);
        $display("lock test done");
        // dropping active clears a half-done count
        bus(1, 8'h18, 32'h05);
        cnt[0] = 0;
        i_pin_source.edges(0, 1, 4);
        act = 3'h0;
        @(posedge sys_clk);
        #1 act = 3'h1;
        i_pin_source.edges(0, 1, 4);
        settle_check(0, 0);
        i_pin_source.edges(0, 1, 4);
        settle_check(0, 1);
        $display("divider clear test done");
        // mid-run reset, then an ignored unmapped write
        bus(1, 8'h1c, 32'h0505);
        resetn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'b1;
        bus(1, 8'h40, 32'h0505);
        bus(0, 8'h1c, 32'h0);
        bus(0, 8'h18, 32'h0);
        bus(0, 8'h40, 32'h0);
        $display("reset test done");
        tally_and_finish();
    end
    // watchdog against stuck stimulus, about thirteen times the expected run
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
endmodule : capture_conditioning_tb
